// ### core/fault_history_log.sv
// fault history log with holding buffer and parameter access
`timescale 1ns/1ps
`default_nettype none
`include "fault_log_params.svh"
module fault_history_log
    import fault_log_pkg::*;
#(
    parameter int DEPTH = `LOG_DEPTH
) (
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    input wire logic i_par_rd,
    input wire logic i_par_wr,
    input wire logic [15:0] i_par_addr,
    input wire logic [15:0] i_par_wdata,
    input wire fault_evt_t i_fault,
    input wire logic [28:0] i_op_hours,
    output logic [15:0] o_par_rdata,
    output logic o_par_ack,
    output logic o_par_err,
    output logic [$clog2(DEPTH+1)-1:0] o_log_count
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);

    // pointer arithmetic wraps only on a power of two
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("DEPTH must be a power of two, at least 2");
    end

    erase_st_t st_r;
    logic [AW-1:0] wr_ptr_r;
    logic [CW-1:0] count_r;
    logic [CW-1:0] rd_ofs_r;
    entry_t hold_r;
    entry_t rd_entry;
    entry_t new_entry;
    logic [AW-1:0] rd_idx;
    logic erase_go;
    logic erase_wr;
    logic rewind_wr;
    logic code_rd;
    logic adv;
    logic drop;
    logic full;
    logic [2:0] sev_in;

    assign erase_go = (st_r == ST_ERASE);
    assign erase_wr = i_par_wr && i_par_addr == `ADDR_ERASE
        && i_par_wdata == `CMD_GO;
    assign rewind_wr = i_par_wr && i_par_addr == `ADDR_REWIND
        && i_par_wdata == `CMD_GO;
    assign code_rd = i_par_rd && i_par_addr == `ADDR_CODE;
    assign full = (count_r == CW'(DEPTH));
    assign adv = code_rd && !erase_go && (rd_ofs_r < count_r);
    // oldest slot is overwritten, so offsets shift down by one
    assign drop = i_fault.valid && !erase_go && full
        && (rd_ofs_r != '0 || adv);
    assign rd_idx = wr_ptr_r - count_r[AW-1:0] + rd_ofs_r[AW-1:0];

    assign sev_in = (i_fault.sev > `SEV_MAX) ? `SEV_MAX : i_fault.sev;

    always_comb begin
        new_entry = '0;
        new_entry.code = i_fault.code;
        new_entry.sev = sev_in;
        new_entry.time_s = i_op_hours;
        new_entry.current = i_fault.current;
    end

    fault_entry_store #(
        .DEPTH(DEPTH),
        .AW(AW)
    ) u_store (
        .i_clk(i_ref_clk),
        .i_resetn(i_resetn),
        .i_clear(erase_go),
        .i_wr_en(i_fault.valid),
        .i_wr_idx(erase_go ? '0 : wr_ptr_r),
        .i_wr_data(new_entry),
        .i_rd_idx(rd_idx),
        .o_rd_data(rd_entry)
    );

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            st_r <= ST_IDLE;
        end else begin
            unique case (st_r)
                ST_IDLE: begin
                    if (erase_wr) begin
                        st_r <= ST_ERASE;
                    end
                end
                ST_ERASE: begin
                    st_r <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            wr_ptr_r <= '0;
            count_r <= '0;
        end else if (erase_go) begin
            // a fault landing during the erase is kept, not lost
            wr_ptr_r <= i_fault.valid ? AW'(1) : '0;
            count_r <= i_fault.valid ? CW'(1) : '0;
        end else if (i_fault.valid) begin
            wr_ptr_r <= wr_ptr_r + AW'(1);
            if (!full) begin
                count_r <= count_r + CW'(1);
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rd_ofs_r <= '0;
        end else if (erase_go || rewind_wr) begin
            rd_ofs_r <= '0;
        end else if (adv && !drop) begin
            rd_ofs_r <= rd_ofs_r + CW'(1);
        end else if (drop && !adv) begin
            rd_ofs_r <= rd_ofs_r - CW'(1);
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            hold_r <= '0;
        end else if (erase_go) begin
            hold_r <= '0;
        end else if (code_rd) begin
            hold_r <= adv ? rd_entry : '0;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_par_rdata <= '0;
            o_par_ack <= 1'b0;
            o_par_err <= 1'b0;
        end else begin
            o_par_ack <= i_par_rd || i_par_wr;
            o_par_err <= 1'b0;
            o_par_rdata <= '0;
            if (i_par_rd || i_par_wr) begin
                case (i_par_addr)
                    `ADDR_ERASE: o_par_rdata <= {15'h0, erase_go};
                    `ADDR_REWIND: o_par_rdata <= '0;
                    `ADDR_CODE: o_par_rdata <= adv ? rd_entry.code : '0;
                    `ADDR_SEV: o_par_rdata <= {13'h0, hold_r.sev};
                    `ADDR_TIME_HI: o_par_rdata <= {3'h0, hold_r.time_s[28:16]};
                    `ADDR_TIME_LO: o_par_rdata <= hold_r.time_s[15:0];
                    `ADDR_CUR: o_par_rdata <= hold_r.current;
                    default: o_par_err <= 1'b1;
                endcase
                if (i_par_wr) begin
                    o_par_rdata <= '0;
                end
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_log_count <= '0;
        end else if (erase_go) begin
            o_log_count <= i_fault.valid ? CW'(1) : '0;
        end else if (i_fault.valid && !full) begin
            o_log_count <= count_r + CW'(1);
        end
    end

    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_resetn);

    sequence s_take;
        code_rd && adv;
    endsequence

    sequence s_erase_req;
        erase_wr && st_r == ST_IDLE;
    endsequence

    a_sev_range: assert property (hold_r.sev <= `SEV_MAX)
        else $error("held severity outside 0..4");
    a_erase_clears: assert property (s_erase_req |=> erase_go ##1
        (count_r <= CW'(1) && hold_r == '0))
        else $error("erase left entries behind");
    a_erase_polls: assert property (s_erase_req ##1
        (i_par_rd && i_par_addr == `ADDR_ERASE) |=>
        o_par_ack && o_par_rdata == 16'h1 ##1 !erase_go)
        else $error("erase busy flag wrong");
    a_code_capture: assert property (s_take |=>
        hold_r.code == $past(rd_entry.code)
        && hold_r.time_s == $past(rd_entry.time_s))
        else $error("holding buffer missed entry");
    a_sev_from_hold: assert property ((i_par_rd &&
        i_par_addr == `ADDR_SEV && !i_par_wr) |=>
        o_par_rdata == {13'h0, $past(hold_r.sev)})
        else $error("severity not from holding buffer");
    a_ptr_advance: assert property ((s_take ##0 !drop && !rewind_wr)
        |=> rd_ofs_r == $past(rd_ofs_r) + CW'(1))
        else $error("read pointer did not advance");
    a_rewind_oldest: assert property (rewind_wr |=> rd_ofs_r == '0)
        else $error("rewind did not reach oldest");
    a_current_kept: assert property (s_take |=>
        hold_r.current == $past(rd_entry.current))
        else $error("motor current not captured");
    a_time_stamp: assert property (i_fault.valid && !erase_go |=>
        o_log_count != '0
        && u_store.mem_r[$past(wr_ptr_r)].time_s == $past(i_op_hours))
        else $error("fault time not stored");
    a_empty_zero: assert property ((code_rd && !adv && !erase_go) |=>
        o_par_rdata == 16'h0 && hold_r == '0)
        else $error("empty read returned data");
endmodule // fault_history_log
`default_nettype wire

// ### core/fault_log_params.svh
// constants for the fault history log
// Functional notes
// - Severity codes are 0 warning, 1 quick stop to 7, 2 quick stop to 8/9, 3 fatal resettable, 4 fatal not resettable.
// - Writing 1 to the erase parameter deletes every stored entry.
// - The erase parameter reads 0 once the erase is complete, and the master polls for that 0.
// - Each fault code read copies the whole entry at the read pointer into the holding buffer.
// - Severity, time and current reads are served from the holding buffer, not the live memory.
// - Each fault code read moves the read pointer on to the next entry by itself.
// - Writing 1 to the rewind parameter sets the read pointer to the oldest stored entry.
// - Each entry keeps the motor current as an unsigned 16-bit value in 10 mA steps.
// - Each entry keeps the fault time in seconds from the operating-hours counter, up to 536870911.
`ifndef FAULT_LOG_PARAMS_SVH
`define FAULT_LOG_PARAMS_SVH
`define ADDR_ERASE 16'h3b08
`define ADDR_REWIND 16'h3b0a
`define ADDR_CODE 16'h3c02
`define ADDR_SEV 16'h3c04
`define ADDR_TIME_HI 16'h3c06
`define ADDR_TIME_LO 16'h3c07
`define ADDR_CUR 16'h3c12
`define CMD_GO 16'h0001
`define SEV_MAX 3'h4
`define TIME_MAX 29'h1fffffff
`define CUR_LSB_MA 10
`define LOG_DEPTH 8
`endif

// ### core/fault_log_pkg.sv
// types shared by the fault history log
package fault_log_pkg;
    // severity classes
    typedef enum logic [2:0] {
        SEV_WARN = 3'h0,
        SEV_STOP7 = 3'h1,
        SEV_STOP89 = 3'h2,
        SEV_FATAL_RST = 3'h3,
        SEV_FATAL = 3'h4
    } sev_t;
    typedef struct packed {
        logic valid;
        logic [15:0] code;
        logic [2:0] sev;
        logic [15:0] current;
    } fault_evt_t;
    typedef struct packed {
        logic [15:0] code;
        logic [2:0] sev;
        logic [28:0] time_s;
        logic [15:0] current;
    } entry_t;
    typedef enum logic {ST_IDLE, ST_ERASE} erase_st_t;
endpackage

// ### core/fault_entry_store.sv
// flip-flop storage for fault log entries
`timescale 1ns/1ps
`default_nettype none
module fault_entry_store
    import fault_log_pkg::*;
#(
    parameter int DEPTH = 8,
    parameter int AW = 3
) (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_clear,
    input wire logic i_wr_en,
    input wire logic [AW-1:0] i_wr_idx,
    input wire entry_t i_wr_data,
    input wire logic [AW-1:0] i_rd_idx,
    output entry_t o_rd_data
);
    entry_t mem_r [DEPTH];

    genvar g;
    generate
        for (g = 0; g < DEPTH; g++) begin : g_entry
            // a write beats a clear on the same slot
            always_ff @(posedge i_clk or negedge i_resetn) begin
                if (!i_resetn) begin
                    mem_r[g] <= '0;
                end else if (i_wr_en && i_wr_idx == AW'(g)) begin
                    mem_r[g] <= i_wr_data;
                end else if (i_clear) begin
                    mem_r[g] <= '0;
                end
            end
        end
    endgenerate

    assign o_rd_data = mem_r[i_rd_idx];
endmodule // fault_entry_store
`default_nettype wire

// ### dv/fault_bus_master.sv
// fieldbus master model for the parameter port
`timescale 1ns/1ps
`default_nettype none
`include "fault_log_params.svh"
module fault_bus_master (
    input wire logic i_ref_clk,
    input wire logic [15:0] i_par_rdata,
    input wire logic i_par_ack,
    input wire logic i_par_err,
    output logic o_par_rd,
    output logic o_par_wr,
    output logic [15:0] o_par_addr,
    output logic [15:0] o_par_wdata
);
    initial begin
        o_par_rd = 1'b0;
        o_par_wr = 1'b0;
        o_par_addr = 16'h0000;
        o_par_wdata = 16'h0000;
    end
    // one-cycle strobe, answer taken one cycle later
    task automatic xfer(input logic wr, input logic [15:0] addr,
            input logic [15:0] wdata, output logic [15:0] rdata,
            output logic err, output logic ok);
        @(posedge i_ref_clk);
        #1;
        o_par_rd = !wr;
        o_par_wr = wr;
        o_par_addr = addr;
        o_par_wdata = wdata;
        @(posedge i_ref_clk);
        #1;
        o_par_rd = 1'b0;
        o_par_wr = 1'b0;
        // released bus shows no stale value
        o_par_addr = ~addr;
        o_par_wdata = ~wdata;
        rdata = i_par_rdata;
        err = i_par_err;
        ok = (i_par_ack === 1'b1);
    endtask
    // erase with 1, read back while busy, poll until 0
    task automatic erase_log(output logic ok, output logic [15:0] busy);
        logic [15:0] d;
        logic e;
        logic k;
        @(posedge i_ref_clk);
        #1;
        o_par_wr = 1'b1;
        o_par_addr = `ADDR_ERASE;
        o_par_wdata = `CMD_GO;
        @(posedge i_ref_clk);
        #1;
        ok = (i_par_ack === 1'b1);
        // read right behind the write lands in the busy cycle
        o_par_wr = 1'b0;
        o_par_rd = 1'b1;
        o_par_wdata = ~`CMD_GO;
        @(posedge i_ref_clk);
        #1;
        o_par_rd = 1'b0;
        o_par_addr = ~`ADDR_ERASE;
        busy = i_par_rdata;
        ok = ok && (i_par_ack === 1'b1);
        d = busy;
        // bounded poll, a stuck erase fails
        for (int i = 0; i < 8 && d !== 16'h0000; i++) begin
            xfer(1'b0, `ADDR_ERASE, 16'h0000, d, e, k);
        end
        ok = ok && (d === 16'h0000);
    endtask
endmodule // fault_bus_master
`default_nettype wire

// ### dv/fault_history_log_tb.sv
// self-checking bench for the fault history log
`timescale 1ns/1ps
`default_nettype none
`include "fault_log_params.svh"
module fault_history_log_tb;
    import fault_log_pkg::*;
    logic i_ref_clk = 1'b0;
    logic i_resetn = 1'b0;
    fault_evt_t i_fault = '0;
    logic [28:0] i_op_hours = 29'h0;
    logic par_rd;
    logic par_wr;
    logic [15:0] par_addr;
    logic [15:0] par_wdata;
    logic [15:0] par_rdata;
    logic par_ack;
    logic par_err;
    logic [3:0] log_count;
    int n_mismatch = 0;
    int n_compared = 0;
    logic [15:0] rd_val;
    logic rd_err;
    logic rd_ok;
    logic [15:0] busy_val;
    always #50 i_ref_clk = ~i_ref_clk;
    fault_history_log #(.DEPTH(8)) u_fault_history_log (
        .i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_par_rd(par_rd),
        .i_par_wr(par_wr), .i_par_addr(par_addr), .i_par_wdata(par_wdata),
        .i_fault(i_fault), .i_op_hours(i_op_hours),
        .o_par_rdata(par_rdata), .o_par_ack(par_ack), .o_par_err(par_err),
        .o_log_count(log_count));
    fault_bus_master u_fault_bus_master (
        .i_ref_clk(i_ref_clk), .i_par_rdata(par_rdata), .i_par_ack(par_ack),
        .i_par_err(par_err), .o_par_rd(par_rd), .o_par_wr(par_wr),
        .o_par_addr(par_addr), .o_par_wdata(par_wdata));
    task automatic summarize();
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd_chk(input logic [15:0] addr, input logic [15:0] exp);
        u_fault_bus_master.xfer(1'b0, addr, 16'h0000, rd_val, rd_err, rd_ok);
        check({15'h0, rd_ok}, 16'h0001);
        check(rd_val, exp);
    endtask
    task automatic wr(input logic [15:0] addr, input logic [15:0] data);
        u_fault_bus_master.xfer(1'b1, addr, data, rd_val, rd_err, rd_ok);
    endtask
    function automatic logic [15:0] code_of(input int i);
        return 16'h0a10 + 16'(i);
    endfunction
    function automatic logic [15:0] cur_of(input int i);
        return 16'hfff0 - 16'(i);
    endfunction
    function automatic logic [28:0] time_of(input int i);
        return (i == 0) ? `TIME_MAX : 29'h10001 * 29'(i);
    endfunction
    // event 5 carries an out-of-range class
    task automatic inject(input int i);
        @(posedge i_ref_clk);
        #1;
        i_fault = {1'b1, code_of(i), (i == 5) ? 3'h7 : 3'(i), cur_of(i)};
        i_op_hours = time_of(i);
        @(posedge i_ref_clk);
        #1;
        i_fault.valid = 1'b0;
    endtask
    initial begin
        #500000;
        n_mismatch++;
        summarize();
    end
    initial begin
        logic [28:0] t;
        repeat (10) @(posedge i_ref_clk);
        #1;
        i_resetn = 1'b1;
        rd_chk(`ADDR_CODE, 16'h0000);
        rd_chk(`ADDR_SEV, 16'h0000);
        for (int i = 0; i < 6; i++) inject(i);
        @(posedge i_ref_clk);
        #1;
        check({12'h0, log_count}, 16'h0006);
        for (int i = 0; i < 6; i++) begin
            t = time_of(i);
            rd_chk(`ADDR_CODE, code_of(i));
            rd_chk(`ADDR_SEV, (i > 4) ? 16'h0004 : 16'(i));
            rd_chk(`ADDR_TIME_HI, {3'h0, t[28:16]});
            rd_chk(`ADDR_TIME_LO, t[15:0]);
            rd_chk(`ADDR_CUR, cur_of(i));
        end
        rd_chk(`ADDR_CODE, 16'h0000);
        rd_chk(`ADDR_CUR, 16'h0000);
        wr(`ADDR_REWIND, `CMD_GO);
        check({15'h0, rd_ok}, 16'h0001);
        rd_chk(`ADDR_CODE, code_of(0));
        rd_chk(`ADDR_CODE, code_of(1));
        wr(`ADDR_REWIND, `CMD_GO);
        rd_chk(`ADDR_CUR, cur_of(1));
        rd_chk(`ADDR_SEV, 16'h0001);
        rd_chk(16'h3c00, 16'h0000);
        check({15'h0, rd_err}, 16'h0001);
        wr(`ADDR_ERASE, 16'h0002);
        check({12'h0, log_count}, 16'h0006);
        u_fault_bus_master.erase_log(rd_ok, busy_val);
        check({15'h0, rd_ok}, 16'h0001);
        check(busy_val, 16'h0001);
        check({12'h0, log_count}, 16'h0000);
        rd_chk(`ADDR_CODE, 16'h0000);
        // one past full: the oldest entry is dropped
        for (int i = 0; i < 9; i++) inject(i);
        @(posedge i_ref_clk);
        #1;
        check({12'h0, log_count}, 16'h0008);
        rd_chk(`ADDR_CODE, code_of(1));
        rd_chk(`ADDR_CUR, cur_of(1));
        rd_chk(`ADDR_CODE, code_of(2));
        summarize();
    end
endmodule // fault_history_log_tb
`default_nettype wire
